// *** fcc_crc64_byte.sv ***
/*
 fcc_crc64_byte: one byte step of the 64-bit crc, data bits taken lsb first.
 assumes: caller registers the result; purely combinational.
*/
`timescale 1ns/1ps
module fcc_crc64_byte
	import fcc_pkg::*;
(
	input  wire logic [63:0] crcIn,
	input  wire logic [7:0]  dataIn,
	output logic      [63:0] crcOut
);
	// ===================================================
	// bitwise shift through the generator
	always_comb begin
		logic fb;
		fb = 1'b0;
		crcOut = crcIn;
		for (int i = 0; i < 8; i++) begin
			fb = crcOut[63] ^ dataIn[i]; // RULE2
			crcOut = {crcOut[62:0], 1'b0} ^ (fb ? CRC_POLY : 64'h0000000000000000); // RULE1
		end
	end
endmodule

// *** fcc_dev.sv ***
/*
 fcc_dev: flash-side crc check engine with its serial command front end.
 assumes: link logic runs on the host-made link clock, array reads and crc on sys_clk;
 array answers each arrReq with one arrAck carrying the byte at arrAddr.
*/
// Contract
// RULE1: crc uses the 64-bit generator polynomial
// RULE2: bytes fed lsb first, seed zero
// RULE3: whole array or host given range
// RULE4: compare, fail shows in flag bit 4
// RULE5: computed crc stored only on mismatch
// RULE6: opcode 96h reads readback, low byte first
// RULE7: readback cleared at each check start
// RULE8: readback cleared on reset, software reset
// RULE9: readback read past its end gives 00h
// RULE10: host sends 9Bh then 27h
// RULE11: option FFh selects whole array
// RULE12: expected crc follows, low byte first
// RULE13: select rising confirms and starts check
// RULE14: option FEh selects range with addresses
// RULE15: range: start then stop, low first
// RULE16: busy while computing, ready after result
`timescale 1ns/1ps
module fcc_dev
	import fcc_pkg::*;
#(
	parameter int ADDR_W = 24
)(
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	fcc_link_if.dev                link,
	output logic                   arrReq,
	output logic      [ADDR_W-1:0] arrAddr,
	input  wire logic              arrAck,
	input  wire logic [7:0]        arrData,
	output logic                   crcBusy,
	output logic                   crcFail
);
	initial begin
		if (ADDR_W < 1 || ADDR_W > 32)
			$error("fcc_dev: ADDR_W out of range");
	end

	// ===================================================
	// link domain, frame-local state (cleared by select high)
	logic [2:0]  bitCnt, next_bitCnt;
	logic [7:0]  byteCnt, next_byteCnt;
	logic [6:0]  shiftIn, next_shiftIn;
	logic [7:0]  cmd, next_cmd;
	// link domain, held across frames
	logic        seqGood, next_seqGood;
	logic        seqValid, next_seqValid;
	logic        optRange, next_optRange;
	logic [63:0] expCrc, next_expCrc;
	logic [31:0] startAddr, next_startAddr;
	logic [31:0] stopAddr, next_stopAddr;
	logic        rstArmed, next_rstArmed;
	logic        swRstTgl, next_swRstTgl;
	logic        busyL1, busyL2, failL1, failL2;
	logic        misoReg, next_misoReg;
	logic [7:0]  dataByte, curCmd, respByte;
	logic        byteDone;
	// sys domain
	logic [63:0] readback;

	assign dataByte = {shiftIn, link.mosi};
	assign byteDone = (bitCnt == 3'd7);
	assign curCmd   = (byteCnt == 8'h00) ? dataByte : cmd;

	always_comb begin
		int k;
		k = int'(byteCnt);
		next_bitCnt    = bitCnt + 3'd1;
		next_byteCnt   = byteCnt;
		next_shiftIn   = dataByte[6:0];
		next_cmd       = cmd;
		next_seqGood   = seqGood;
		next_seqValid  = seqValid;
		next_optRange  = optRange;
		next_expCrc    = expCrc;
		next_startAddr = startAddr;
		next_stopAddr  = stopAddr;
		next_rstArmed  = rstArmed;
		next_swRstTgl  = swRstTgl;
		if (byteCnt == 8'h00 && bitCnt == 3'd0) begin
			next_seqValid = 1'b0;
			next_seqGood  = 1'b1;
		end
		if (byteDone) begin
			if (byteCnt != 8'hFF)
				next_byteCnt = byteCnt + 8'h01;
			if (k == 0) begin
				next_cmd      = dataByte;
				next_seqGood  = (dataByte == OP_ACTIVATE); // RULE10
				next_rstArmed = (dataByte == OP_RST_ENABLE);
				if (dataByte == OP_RST_MEMORY && rstArmed)
					next_swRstTgl = ~swRstTgl; // RULE8
			end else if (curCmd == OP_ACTIVATE) begin
				if (k == 1 && dataByte != SUB_CRC)
					next_seqGood = 1'b0; // RULE10
				if (k == 2) begin
					next_optRange = (dataByte == OPT_RANGE); // RULE14
					if (dataByte != OPT_WHOLE && dataByte != OPT_RANGE) // RULE11
						next_seqGood = 1'b0;
				end
				if (k >= EXP_FIRST && k < START_FIRST)
					next_expCrc[(k - EXP_FIRST) * 8 +: 8] = dataByte; // RULE12
				if (k >= START_FIRST && k < STOP_FIRST)
					next_startAddr[(k - START_FIRST) * 8 +: 8] = dataByte; // RULE15
				if (k >= STOP_FIRST && k < RANGE_BYTES)
					next_stopAddr[(k - STOP_FIRST) * 8 +: 8] = dataByte; // RULE15
			end
			// valid only when the frame holds exactly the needed bytes
			next_seqValid = next_seqGood && (curCmd == OP_ACTIVATE) &&
				(k + 1 == (next_optRange ? RANGE_BYTES : WHOLE_BYTES)); // RULE3
		end
	end

	always_ff @(posedge link.sclk or posedge link.csN) begin
		if (link.csN) begin
			bitCnt  <= 3'd0;
			byteCnt <= 8'h00;
			shiftIn <= 7'h00;
			cmd     <= 8'h00;
		end else begin
			bitCnt  <= next_bitCnt;
			byteCnt <= next_byteCnt;
			shiftIn <= next_shiftIn;
			cmd     <= next_cmd;
		end
	end

	// reset is only released while the link is idle
	always_ff @(posedge link.sclk or posedge sys_rst) begin
		if (sys_rst) begin
			seqGood   <= 1'b0;
			seqValid  <= 1'b0;
			optRange  <= 1'b0;
			expCrc    <= 64'h0000000000000000;
			startAddr <= 32'h00000000;
			stopAddr  <= 32'h00000000;
			rstArmed  <= 1'b0;
			swRstTgl  <= 1'b0;
			busyL1    <= 1'b0;
			busyL2    <= 1'b0;
			failL1    <= 1'b0;
			failL2    <= 1'b0;
		end else begin
			seqGood   <= next_seqGood;
			seqValid  <= next_seqValid;
			optRange  <= next_optRange;
			expCrc    <= next_expCrc;
			startAddr <= next_startAddr;
			stopAddr  <= next_stopAddr;
			rstArmed  <= next_rstArmed;
			swRstTgl  <= next_swRstTgl;
			busyL1    <= crcBusy;
			busyL2    <= busyL1;
			failL1    <= crcFail;
			failL2    <= failL1;
		end
	end

	// ===================================================
	// link domain, answer bytes shifted out on the falling edge
	// readback is read unsynchronised: it only changes as busy rises or falls, or on software reset
	always_comb begin
		int r;
		r = int'(byteCnt) - 1;
		respByte = BYTE_ZERO;
		if (byteCnt != 8'h00) begin
			unique case (cmd)
				OP_READ_RB: begin
					if (r < CRC_BYTES && r < RB_LOCATIONS)
						respByte = readback[r * 8 +: 8]; // RULE6 RULE9
				end
				OP_READ_STATUS: respByte[SR_BUSY] = busyL2; // RULE16
				OP_READ_FLAG: begin
					respByte[FSR_READY]    = ~busyL2; // RULE16
					respByte[FSR_CRC_FAIL] = failL2; // RULE4
				end
				default: respByte = BYTE_ZERO;
			endcase
		end
		next_misoReg = respByte[3'd7 - bitCnt];
	end

	always_ff @(negedge link.sclk or posedge link.csN) begin
		if (link.csN)
			misoReg <= 1'b0;
		else
			misoReg <= next_misoReg;
	end
	assign link.miso = misoReg;

	// ===================================================
	// sys domain: crossings
	logic csS1, csS2, csPrev, vS1, vS2, tS1, tS2, tPrev;
	logic csRise, swReset;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{csS1, csS2, csPrev} <= 3'b111;
			{vS1, vS2, tS1, tS2, tPrev} <= 5'b00000;
		end else begin
			csS1   <= link.csN;
			csS2   <= csS1;
			csPrev <= csS2;
			vS1    <= seqValid;
			vS2    <= vS1;
			tS1    <= swRstTgl;
			tS2    <= tS1;
			tPrev  <= tS2;
		end
	end
	assign csRise  = csS2 & ~csPrev;
	assign swReset = tS2 ^ tPrev;

	// ===================================================
	// sys domain: check engine
	typedef enum logic [1:0] {S_IDLE, S_FETCH, S_CHECK} fcc_state_e;
	fcc_state_e  state, next_state;
	logic [ADDR_W-1:0] addr, next_addr, lastAddr, next_lastAddr;
	logic [63:0] crc, next_crc, expHeld, next_expHeld, next_readback, crcStep;
	logic        next_busy, next_fail, next_arrReq;

	fcc_crc64_byte u_step (
		.crcIn  (crc),
		.dataIn (arrData),
		.crcOut (crcStep)
	);

	always_comb begin
		next_state    = state;
		next_addr     = addr;
		next_lastAddr = lastAddr;
		next_crc      = crc;
		next_expHeld  = expHeld;
		next_readback = readback;
		next_busy     = crcBusy;
		next_fail     = crcFail;
		next_arrReq   = 1'b0;
		unique case (state)
			S_IDLE: begin
				// link fields are static here: the link clock stops with select high
				if (csRise && vS2) begin // RULE13
					next_crc      = CRC_SEED; // RULE2
					next_readback = RB_RESET; // RULE7
					next_expHeld  = expCrc;
					next_busy     = 1'b1; // RULE16
					if (optRange) begin
						next_addr     = startAddr[ADDR_W-1:0]; // RULE3
						next_lastAddr = stopAddr[ADDR_W-1:0];
					end else begin
						next_addr     = '0;
						next_lastAddr = '1;
					end
					// an inverted range computes over no bytes
					next_state  = (optRange && stopAddr < startAddr) ? S_CHECK : S_FETCH;
					next_arrReq = (next_state == S_FETCH);
				end
			end
			S_FETCH: begin
				next_arrReq = 1'b1;
				if (arrAck) begin
					next_crc = crcStep; // RULE1
					if (addr == lastAddr) begin
						next_state  = S_CHECK;
						next_arrReq = 1'b0;
					end else begin
						next_addr = addr + 1'b1;
					end
				end
			end
			S_CHECK: begin
				next_fail = (crc != expHeld); // RULE4
				if (crc != expHeld)
					next_readback = crc; // RULE5
				next_busy  = 1'b0; // RULE16
				next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
		if (swReset) begin
			next_state    = S_IDLE;
			next_readback = RB_RESET; // RULE8
			next_busy     = 1'b0;
			next_fail     = 1'b0;
			next_arrReq   = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state    <= S_IDLE;
			addr     <= '0;
			lastAddr <= '0;
			crc      <= CRC_SEED;
			expHeld  <= 64'h0000000000000000;
			readback <= RB_RESET; // RULE8
			crcBusy  <= 1'b0;
			crcFail  <= 1'b0;
			arrReq   <= 1'b0;
		end else begin
			state    <= next_state;
			addr     <= next_addr;
			lastAddr <= next_lastAddr;
			crc      <= next_crc;
			expHeld  <= next_expHeld;
			readback <= next_readback;
			crcBusy  <= next_busy;
			crcFail  <= next_fail;
			arrReq   <= next_arrReq;
		end
	end
	assign arrAddr = addr;
endmodule

// *** fcc_host.sv ***
/*
 fcc_host: host controller end; frames crc check, readback and status commands.
 assumes: link clock derived here from sys_clk; one command at a time from the user.
*/
`timescale 1ns/1ps
module fcc_host
	import fcc_pkg::*;
#(
	parameter int HALF = SCLK_HALF
)(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	fcc_link_if.host         link,
	input  wire logic        cmdValid,
	input  wire fcc_op_e     cmdOp,
	input  wire logic [63:0] cmdExpCrc,
	input  wire logic [31:0] cmdStartAddr,
	input  wire logic [31:0] cmdStopAddr,
	output logic             cmdReady,
	output logic             rspValid,
	output logic      [63:0] rspData
);
	initial begin
		if (HALF < 3 || HALF > 255)
			$error("fcc_host: HALF must allow the miso synchroniser to settle");
	end

	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} fcc_hstate_e;
	fcc_hstate_e state, next_state;
	fcc_op_e     op, next_op;
	logic [63:0] exp, next_exp, next_rspData;
	logic [31:0] sAddr, next_sAddr, eAddr, next_eAddr;
	logic [7:0]  div, next_div, bitPos, next_bitPos, lastBit, next_lastBit, rxByte, next_rxByte;
	logic        sclk, next_sclk, csN, next_csN, mosi, next_mosi, next_rspValid;
	logic        misoS1, misoS2;

	// ===================================================
	// frame byte at a given index
	function automatic logic [7:0] txByte(input int i, input fcc_op_e o, input logic [63:0] e,
	                                      input logic [31:0] s, input logic [31:0] t);
		logic [7:0] b;
		b = BYTE_ZERO;
		unique case (o)
			FCC_READ_RB:     b = (i == 0) ? OP_READ_RB : BYTE_ZERO;
			FCC_READ_FLAG:   b = (i == 0) ? OP_READ_FLAG : BYTE_ZERO;
			FCC_READ_STATUS: b = (i == 0) ? OP_READ_STATUS : BYTE_ZERO;
			FCC_RST_ENABLE:  b = OP_RST_ENABLE;
			FCC_RST_MEMORY:  b = OP_RST_MEMORY;
			default: begin
				if (i == 0)
					b = OP_ACTIVATE; // RULE10
				else if (i == 1)
					b = SUB_CRC; // RULE10
				else if (i == 2)
					b = (o == FCC_CHECK_RANGE) ? OPT_RANGE : OPT_WHOLE; // RULE11 RULE14
				else if (i < START_FIRST)
					b = e[(i - EXP_FIRST) * 8 +: 8]; // RULE12
				else if (i < STOP_FIRST)
					b = s[(i - START_FIRST) * 8 +: 8]; // RULE15
				else
					b = t[(i - STOP_FIRST) * 8 +: 8]; // RULE15
			end
		endcase
		return b;
	endfunction

	function automatic logic [7:0] frameBits(input fcc_op_e o);
		unique case (o)
			FCC_CHECK_WHOLE: frameBits = 8'(WHOLE_BYTES * 8);
			FCC_CHECK_RANGE: frameBits = 8'(RANGE_BYTES * 8);
			FCC_READ_RB:     frameBits = 8'((1 + CRC_BYTES) * 8);
			FCC_READ_FLAG, FCC_READ_STATUS: frameBits = 8'(READ_BYTES * 8);
			default:         frameBits = 8'h08;
		endcase
	endfunction

	// ===================================================
	// frame sequencer
	always_comb begin
		logic [7:0] nb;
		logic [7:0] b;
		nb = 8'h00;
		b  = BYTE_ZERO;
		next_state = state;
		next_op = op;
		next_exp = exp;
		next_sAddr = sAddr;
		next_eAddr = eAddr;
		next_div = div + 8'h01;
		next_bitPos = bitPos;
		next_lastBit = lastBit;
		next_rxByte = rxByte;
		next_sclk = sclk;
		next_csN = csN;
		next_mosi = mosi;
		next_rspData = rspData;
		next_rspValid = 1'b0;
		unique case (state)
			H_IDLE: begin
				next_div = 8'h00;
				if (cmdValid) begin
					next_op = cmdOp;
					next_exp = cmdExpCrc;
					next_sAddr = cmdStartAddr;
					next_eAddr = cmdStopAddr;
					next_bitPos = 8'h00;
					next_lastBit = frameBits(cmdOp) - 8'h01;
					next_csN = 1'b0;
					b = txByte(0, cmdOp, cmdExpCrc, cmdStartAddr, cmdStopAddr);
					next_mosi = b[7];
					next_state = H_LOW;
				end
			end
			H_LOW: if (div == 8'(HALF - 1)) begin
				next_div = 8'h00;
				next_sclk = 1'b1;
				next_state = H_HIGH;
			end
			H_HIGH: if (div == 8'(HALF - 1)) begin
				next_div = 8'h00;
				next_sclk = 1'b0;
				next_rxByte = {rxByte[6:0], misoS2};
				if (bitPos[2:0] == 3'd7) begin
					if (op == FCC_READ_RB)
						next_rspData = {rxByte[6:0], misoS2, rspData[63:8]}; // RULE6
					else
						next_rspData = {56'h0, rxByte[6:0], misoS2};
				end
				if (bitPos == lastBit) begin
					next_state = H_TAIL;
				end else begin
					nb = bitPos + 8'h01;
					next_bitPos = nb;
					b = txByte(int'(nb[7:3]), op, exp, sAddr, eAddr);
					next_mosi = b[3'd7 - nb[2:0]];
					next_state = H_LOW;
				end
			end
			H_TAIL: if (div == 8'(HALF - 1)) begin
				next_div = 8'h00;
				if (csN) begin
					next_state = H_IDLE;
					next_rspValid = 1'b1;
				end else begin
					next_csN = 1'b1; // RULE13
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= H_IDLE;
			op <= FCC_CHECK_WHOLE;
			exp <= 64'h0000000000000000;
			sAddr <= 32'h00000000;
			eAddr <= 32'h00000000;
			div <= 8'h00;
			bitPos <= 8'h00;
			lastBit <= 8'h00;
			rxByte <= 8'h00;
			sclk <= 1'b0;
			csN <= 1'b1;
			mosi <= 1'b0;
			rspData <= 64'h0000000000000000;
			rspValid <= 1'b0;
			misoS1 <= 1'b0;
			misoS2 <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			exp <= next_exp;
			sAddr <= next_sAddr;
			eAddr <= next_eAddr;
			div <= next_div;
			bitPos <= next_bitPos;
			lastBit <= next_lastBit;
			rxByte <= next_rxByte;
			sclk <= next_sclk;
			csN <= next_csN;
			mosi <= next_mosi;
			rspData <= next_rspData;
			rspValid <= next_rspValid;
			misoS1 <= link.miso;
			misoS2 <= misoS1;
		end
	end

	assign cmdReady  = (state == H_IDLE);
	assign link.sclk = sclk;
	assign link.csN  = csN;
	assign link.mosi = mosi;
endmodule

// *** fcc_link_if.sv ***
/*
 fcc_link_if: single-lane serial link between host controller and flash device.
 assumes: host drives clock, select and data out; link clock stops while select is high.
*/
`timescale 1ns/1ps
interface fcc_link_if;
	logic sclk;
	logic csN;
	logic mosi;
	logic miso;

	modport dev  (input sclk, input csN, input mosi, output miso);
	modport host (output sclk, output csN, output mosi, input miso);
endinterface

// *** fcc_link_properties.sv ***
/*
 fcc_link_properties: concurrent checks on the serial link and the check engine status.
 assumes: instantiated beside the link interface by the bench; host made with HALF = 4.
*/
`timescale 1ns/1ps
module fcc_link_properties #(
	parameter int ADDR_W = 24
)(
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              sclk,
	input  wire logic              csN,
	input  wire logic              mosi,
	input  wire logic              miso,
	input  wire logic              arrReq,
	input  wire logic [ADDR_W-1:0] arrAddr,
	input  wire logic              arrAck,
	input  wire logic              crcBusy,
	input  wire logic              crcFail
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// ===================================================
	// helper: link clock rises per frame
	logic [8:0] riseCnt;
	logic [8:0] next_riseCnt;
	logic       sclkQ;
	logic       next_sclkQ;

	always_comb begin
		next_sclkQ = sclk;
		next_riseCnt = csN ? 9'h000 : riseCnt + {8'h00, sclk & ~sclkQ};
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			riseCnt <= 9'h000;
			sclkQ <= 1'b0;
		end else begin
			riseCnt <= next_riseCnt;
			sclkQ <= next_sclkQ;
		end
	end

	// ===================================================
	// link framing
	sclk_idle_a: assert property (csN |-> !sclk) else $error("link clock runs outside frame");
	miso_idle_a: assert property (csN && $past(csN) |-> !miso) else $error("data out not low while idle");
	sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("clock high phase wrong");
	sclk_low_a: assert property ($fell(sclk) |-> !sclk[*4]) else $error("clock low phase wrong");
	mosi_stable_a: assert property (sclk |-> $stable(mosi)) else $error("data moved while clock high");
	frame_bytes_a: assert property ($rose(csN) |-> riseCnt != 9'h000 && riseCnt[2:0] == 3'h0)
		else $error("frame not whole bytes");

	// ===================================================
	// check engine
	busy_start_a: assert property ($rose(crcBusy) |-> csN ##[0:4] arrReq) else $error("check start late");
	arr_hold_a: assert property (arrReq && !arrAck |=> arrReq && $stable(arrAddr))
		else $error("array request dropped");
	busy_end_a: assert property ($fell(crcBusy) |-> !arrReq && $past(arrAck, 2)) else $error("busy end misplaced");
	fail_post_a: assert property ($rose(crcFail) |-> $fell(crcBusy)) else $error("fail flag set while busy");
endmodule

// *** fcc_pkg.sv ***
/*
 fcc_pkg: shared constants and types of the flash array integrity checker.
 assumes: imported whole by the crc step, device and host files and the bench; the link interface does not import it.
*/
package fcc_pkg;
	// ===================================================
	// command set
	localparam logic [7:0]  OP_ACTIVATE    = 8'h9B;
	localparam logic [7:0]  SUB_CRC        = 8'h27;
	localparam logic [7:0]  OPT_WHOLE      = 8'hFF;
	localparam logic [7:0]  OPT_RANGE      = 8'hFE;
	localparam logic [7:0]  OP_READ_RB     = 8'h96;
	localparam logic [7:0]  OP_READ_STATUS = 8'h05;
	localparam logic [7:0]  OP_READ_FLAG   = 8'h70;
	localparam logic [7:0]  OP_RST_ENABLE  = 8'h66;
	localparam logic [7:0]  OP_RST_MEMORY  = 8'h99;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	// ===================================================
	// crc and sequence layout
	localparam logic [63:0] CRC_POLY       = 64'h42F0E1EBA9EA3693;
	localparam logic [63:0] CRC_SEED       = 64'h0000000000000000;
	localparam logic [63:0] RB_RESET       = 64'h0000000000000000;
	localparam int          CRC_BYTES      = 8;
	localparam int          RB_LOCATIONS   = 64;
	localparam int          EXP_FIRST      = 3;
	localparam int          START_FIRST    = 11;
	localparam int          STOP_FIRST     = 15;
	localparam int          WHOLE_BYTES    = 11;
	localparam int          RANGE_BYTES    = 19;
	localparam int          READ_BYTES     = 2;
	// ===================================================
	// status bit positions
	localparam int          SR_BUSY        = 0;
	localparam int          FSR_CRC_FAIL   = 4;
	localparam int          FSR_READY      = 7;
	// ===================================================
	// host timing: sys_clk cycles per half period of the link clock
	localparam int          SCLK_HALF      = 4;

	typedef enum logic [2:0] {
		FCC_CHECK_WHOLE, FCC_CHECK_RANGE, FCC_READ_RB, FCC_READ_FLAG,
		FCC_READ_STATUS, FCC_RST_ENABLE, FCC_RST_MEMORY
	} fcc_op_e;
endpackage

// *** flash_crc_check_engine_bench.sv ***
/*
 flash_crc_check_engine_bench: host end and device end joined by the link, with a small array model.
 assumes: array of 16 bytes (ADDR_W 4); link clock made by the host end.
*/
`timescale 1ns/1ps
module flash_crc_check_engine_bench
	import fcc_pkg::*;
;
	localparam int          AW = 4;
	localparam logic [31:0] Z  = 32'h00000000;

	logic              sys_clk      = 1'b0;
	logic              sys_rst      = 1'b0;
	logic              cmdValid     = 1'b0;
	fcc_op_e           cmdOp        = FCC_READ_FLAG;
	logic [63:0]       cmdExpCrc    = 64'h0;
	logic [31:0]       cmdStartAddr = 32'h0;
	logic [31:0]       cmdStopAddr  = 32'h0;
	logic              arrAck       = 1'b0;
	logic [7:0]        arrData      = 8'h00;
	logic              cmdReady;
	logic              rspValid;
	logic              arrReq;
	logic              crcBusy;
	logic              crcFail;
	logic [63:0]       rspData;
	logic [63:0]       rsp;
	logic [63:0]       good;
	logic [AW-1:0]     arrAddr;
	logic [7:0]        mem [16];
	int                ackWait      = 0;
	int                error_cnt    = 0;
	int                n_checks     = 0;

	always #10 sys_clk = ~sys_clk;

	fcc_link_if lnk();

	fcc_host i_fcc_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lnk), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdExpCrc(cmdExpCrc), .cmdStartAddr(cmdStartAddr), .cmdStopAddr(cmdStopAddr), .cmdReady(cmdReady),
		.rspValid(rspValid), .rspData(rspData));

	fcc_dev #(.ADDR_W(AW)) i_fcc_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lnk), .arrReq(arrReq),
		.arrAddr(arrAddr), .arrAck(arrAck), .arrData(arrData), .crcBusy(crcBusy), .crcFail(crcFail));

	fcc_link_properties #(.ADDR_W(AW)) i_fcc_link_properties (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.sclk(lnk.sclk), .csN(lnk.csN), .mosi(lnk.mosi), .miso(lnk.miso), .arrReq(arrReq), .arrAddr(arrAddr),
		.arrAck(arrAck), .crcBusy(crcBusy), .crcFail(crcFail));

	// ===================================================
	// array model: the address after each odd one answers slowly, data line scrambled between acks
	always @(posedge sys_clk) begin
		#1;
		if (arrReq === 1'b1 && arrAck !== 1'b1 && ackWait == 0) begin
			arrAck = 1'b1;
			arrData = mem[arrAddr];
			ackWait = arrAddr[0] ? 2 : 0;
		end else begin
			arrAck = 1'b0;
			arrData = ~arrData;
			if (arrReq === 1'b1 && ackWait > 0) ackWait--;
		end
	end

	// ===================================================
	// tasks
	function automatic logic [63:0] crc_of(input int first, input int last);
		logic [63:0] c;
		c = CRC_SEED;
		for (int a = first; a <= last; a++) begin
			for (int i = 0; i < 8; i++) begin
				c = (c[63] ^ mem[a][i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
			end
		end
		return c;
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// called just after an edge; next command is taken the cycle after the answer
	task automatic run(input fcc_op_e op, input logic [63:0] e, input logic [31:0] s, input logic [31:0] t);
		int n;
		cmdOp = op;
		cmdExpCrc = e;
		cmdStartAddr = s;
		cmdStopAddr = t;
		cmdValid = 1'b1;
		@(posedge sys_clk) #1;
		cmdValid = 1'b0;
		for (n = 0; n < 3000 && rspValid !== 1'b1; n++) @(posedge sys_clk) #1;
		chk(rspValid, 64'h1);
		chk(cmdReady, 64'h1);
		rsp = rspData;
	endtask

	task automatic check_op(input fcc_op_e op, input logic [63:0] e, input logic [31:0] s, input logic [31:0] t,
		input logic fail, input logic [63:0] rb);
		int n;
		run(op, e, s, t);
		for (n = 0; n < 20 && crcBusy !== 1'b1; n++) @(posedge sys_clk) #1;
		chk(crcBusy, 64'h1);
		for (n = 0; n < 2000 && crcBusy !== 1'b0; n++) @(posedge sys_clk) #1;
		chk(crcFail, fail);
		run(FCC_READ_FLAG, 64'h0, Z, Z);
		chk(rsp & 64'h90, fail ? 64'h90 : 64'h80);
		run(FCC_READ_STATUS, 64'h0, Z, Z);
		chk(rsp[SR_BUSY], 64'h0);
		run(FCC_READ_RB, 64'h0, Z, Z);
		chk(rsp, rb);
	endtask

	// ===================================================
	// main sequence
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 8'(i * 37) ^ 8'hC3;
		// reset must rise as an event: link-held registers clear on its edge
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		run(FCC_READ_RB, 64'h0, Z, Z);
		chk(rsp, RB_RESET);
		good = crc_of(0, 15);
		check_op(FCC_CHECK_WHOLE, good, Z, Z, 1'b0, RB_RESET);
		check_op(FCC_CHECK_WHOLE, ~good, Z, Z, 1'b1, good);
		good = crc_of(3, 9);
		check_op(FCC_CHECK_RANGE, good ^ 64'h1, 32'h3, 32'h9, 1'b1, good);
		check_op(FCC_CHECK_RANGE, good, 32'h3, 32'h9, 1'b0, RB_RESET);
		good = crc_of(15, 15);
		check_op(FCC_CHECK_RANGE, 64'h0, 32'hF, 32'hF, 1'b1, good);
		// software reset must wipe the failing result left above
		run(FCC_RST_ENABLE, 64'h0, Z, Z);
		run(FCC_RST_MEMORY, 64'h0, Z, Z);
		repeat (5) @(posedge sys_clk) #1;
		chk(crcFail, 64'h0);
		run(FCC_READ_RB, 64'h0, Z, Z);
		chk(rsp, RB_RESET);
		end_of_test();
	end

	// about 24 frames of up to 1300 cycles each plus checks; about 1.6 times that
	initial begin
		#1000000;
		error_cnt++;
		end_of_test();
	end
endmodule
